// *** core/lockstep_compare_monitor.sv ***
// Purpose : Lockstep comparator, self test, error forcing, bus inactivity monitor
// Assumes : Both cores and both irq controllers on clock_in
// Notes   : Registers reached over Avalon-MM with waitrequest
`timescale 1ns/10ps
module lockstep_compare_monitor
  import lockstep_pkg::*;
#(
  parameter int CORE_W        = 32,
  parameter int IRQC_W        = 16,
  parameter int BUS_W         = 16,
  parameter int MASTERS       = 4,
  parameter int CORE_ST_LEN   = CORE_ST_CYC,
  parameter logic [BUS_W-1:0] BUS_CLAMP = '0
) (
  input  wire logic               clock_in,
  input  wire logic               reset_in,
  input  wire logic [7:0]         avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  input  wire logic [3:0]         avs_byteenable_in,
  output logic [31:0]             avs_readdata_out,
  output logic                    avs_waitrequest_out,
  input  wire logic [CORE_W-1:0]  core_main_in,
  input  wire logic [CORE_W-1:0]  core_check_in,
  input  wire logic [IRQC_W-1:0]  irqc_main_in,
  input  wire logic [IRQC_W-1:0]  irqc_check_in,
  input  wire logic               lockstep_in,
  input  wire logic [BUS_W-1:0]   checker_bus_in,
  input  wire logic [MASTERS-1:0] master_active_in,
  input  wire logic [MASTERS-1:0] domain_off_in,
  input  wire logic               error_group_two_in,
  input  wire logic               error_pin_n_in,
  output logic                    compare_error_out,
  output logic                    selftest_error_out,
  output logic                    comparator_status_channel_out,
  output logic                    bus_error_out,
  output logic                    error_group_two_out,
  output logic                    error_pin_n_out,
  output logic                    irq_out
);

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (CORE_W < 2 || IRQC_W < 2 || CORE_W > 32 || IRQC_W > 32 || MASTERS < 1 || BUS_W < 1) begin : g_bad_width
    $error("lockstep_compare_monitor: widths out of range");
  end
  if (CORE_ST_LEN < 2 || CORE_ST_LEN > 65535) begin : g_bad_len
    $error("lockstep_compare_monitor: self test length out of range");
  end

  localparam logic [15:0] CORE_ST_LEN_C = 16'(CORE_ST_LEN);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CORE_W-1:0] main_d1;
    logic [CORE_W-1:0] main_d2;
    blk_s              core;
    blk_s              irqc;
    logic [EVT_W-1:0]  evt;
    logic [EVT_W-1:0]  mask;
    logic              bus_err;
    logic              ack;
    logic [31:0]       rdata;
  } st_s;

  st_s st_r;
  st_s st_nxt;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic differs(input logic [31:0] a, input logic [31:0] b);
    differs = |(a ^ b);
  endfunction : differs

  function automatic mode_e key_to_mode(input logic [3:0] key, input mode_e cur);
    case (key)
      KEY_LOCKSTEP: key_to_mode = MODE_LOCK;
      KEY_SELFTEST: key_to_mode = MODE_SELF;
      KEY_FORCE:    key_to_mode = MODE_FORCE;
      KEY_ST_FORCE: key_to_mode = MODE_STFORCE;
      default:      key_to_mode = cur;
    endcase
  endfunction : key_to_mode

  function automatic logic [31:0] stat_word(input blk_s b);
    stat_word = 32'h0000_0000;
    stat_word[STAT_CMP_BIT]                   = b.cmp_err;
    stat_word[STAT_DONE_BIT]                  = b.st_done;
    stat_word[STAT_FAIL_BIT]                  = b.st_fail;
    stat_word[STAT_MODE_LSB+1:STAT_MODE_LSB]  = b.mode;
  endfunction : stat_word

  // One cycle of a compare block's mode sequencer
  function automatic blk_s blk_step(input blk_s b, input logic mis, input logic st_ok,
                                    input blk_wr_s w, input logic [15:0] st_len);
    blk_s n;
    logic done_now;
    n            = b;
    done_now     = 1'b0;
    n.cmp_now    = 1'b0;
    n.st_err_now = 1'b0;
    case (b.mode)
      MODE_LOCK: begin
        n.cmp_now = mis; // RQ1
      end
      MODE_SELF: begin
        n.cmp_now = 1'b0; // RQ6
        if (!st_ok) begin
          n.st_fail    = 1'b1; // RQ7
          n.st_err_now = 1'b1; // RQ7
        end
        if (b.cnt == st_len - 16'h0001) begin
          n.mode    = MODE_LOCK; // RQ8 RQ9
          n.cnt     = CNT_ZERO;
          n.st_done = 1'b1;
          done_now  = 1'b1;
        end else begin
          n.cnt = b.cnt + 16'h0001;
        end
      end
      MODE_FORCE: begin
        n.cmp_now = mis; // RQ10
        n.mode    = MODE_LOCK; // RQ10
      end
      MODE_STFORCE: begin
        n.cmp_now    = mis; // RQ12
        n.st_err_now = 1'b1; // RQ12
        n.st_fail    = 1'b1;
        n.mode       = MODE_LOCK; // RQ12
      end
      default: begin
        n.mode = MODE_LOCK;
      end
    endcase
    if (w.clr_we) begin
      if (w.clr[STAT_CMP_BIT]) n.cmp_err = 1'b0;
      if (w.clr[STAT_DONE_BIT] && !done_now) n.st_done = 1'b0;
      if (w.clr[STAT_FAIL_BIT] && !n.st_err_now) n.st_fail = 1'b0;
    end
    if (n.cmp_now) n.cmp_err = 1'b1;
    if (w.we) begin
      n.mode = key_to_mode(w.key, n.mode); // RQ3 RQ11
      n.cnt  = CNT_ZERO;
    end
    blk_step = n;
  endfunction : blk_step

  // ------------------------------------------------------------
  // Compare paths
  // ------------------------------------------------------------
  logic [31:0] core_a;
  logic [31:0] core_b;
  logic [31:0] irqc_a;
  logic [31:0] irqc_b;
  logic        core_mis;
  logic        irqc_mis;
  logic        core_st_ok;
  logic        irqc_st_ok;

  always_comb begin
    core_a = 32'(st_r.main_d2); // RQ2
    core_b = 32'(core_check_in);
    irqc_a = 32'(irqc_main_in);
    irqc_b = 32'(irqc_check_in);
    if (st_r.core.mode == MODE_FORCE) begin
      core_a = 32'h0000_0000; // RQ10
      core_b = 32'h0000_0001;
    end
    if (st_r.irqc.mode == MODE_FORCE) begin
      irqc_a = 32'h0000_0000; // RQ10 RQ11
      irqc_b = 32'h0000_0001;
    end
    core_mis   = differs(core_a, core_b);
    irqc_mis   = differs(irqc_a, irqc_b);
    core_st_ok = !differs({16'h0000, st_r.core.cnt}, {16'h0000, st_r.core.cnt})
               && differs({16'h0000, st_r.core.cnt}, {16'h0000, ~st_r.core.cnt}); // RQ6
    irqc_st_ok = !differs({16'h0000, st_r.irqc.cnt}, {16'h0000, st_r.irqc.cnt})
               && differs({16'h0000, st_r.irqc.cnt}, {16'h0000, ~st_r.irqc.cnt}); // RQ6
  end

  // ------------------------------------------------------------
  // Bus access decode
  // ------------------------------------------------------------
  logic    req;
  logic    wr_go;
  logic    lo_lane;
  blk_wr_s core_wr;
  blk_wr_s irqc_wr;
  logic    bus_evt;

  always_comb begin
    req     = avs_read_in || avs_write_in;
    wr_go   = avs_write_in && st_r.ack;
    lo_lane = avs_byteenable_in[0];
    core_wr.we     = wr_go && lo_lane && avs_address_in == CORE_KEY_OFS; // RQ4
    core_wr.key    = avs_writedata_in[3:0];
    core_wr.clr_we = wr_go && lo_lane && avs_address_in == CORE_STAT_OFS;
    core_wr.clr    = avs_writedata_in[2:0];
    irqc_wr.we     = wr_go && lo_lane && avs_address_in == IRQC_KEY_OFS; // RQ4
    irqc_wr.key    = avs_writedata_in[3:0];
    irqc_wr.clr_we = wr_go && lo_lane && avs_address_in == IRQC_STAT_OFS;
    irqc_wr.clr    = avs_writedata_in[2:0];
    bus_evt = lockstep_in && ((checker_bus_in != BUS_CLAMP) // RQ13 RQ14
                              || |(master_active_in & domain_off_in)); // RQ15
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.main_d1 = core_main_in; // RQ2
    st_nxt.main_d2 = st_r.main_d1; // RQ2
    st_nxt.core    = blk_step(st_r.core, core_mis, core_st_ok, core_wr, CORE_ST_LEN_C); // RQ8
    st_nxt.irqc    = blk_step(st_r.irqc, irqc_mis, irqc_st_ok, irqc_wr, IRQC_ST_CYC); // RQ9
    st_nxt.bus_err = bus_evt; // RQ13
    st_nxt.ack     = req && !st_r.ack;
    if (req && !st_r.ack) begin
      case (avs_address_in)
        CORE_KEY_OFS:  st_nxt.rdata = {30'h0000_0000, st_r.core.mode};
        CORE_STAT_OFS: st_nxt.rdata = stat_word(st_r.core);
        IRQC_KEY_OFS:  st_nxt.rdata = {30'h0000_0000, st_r.irqc.mode};
        IRQC_STAT_OFS: st_nxt.rdata = stat_word(st_r.irqc);
        EVT_STAT_OFS:  st_nxt.rdata = 32'(st_r.evt);
        EVT_MASK_OFS:  st_nxt.rdata = 32'(st_r.mask);
        default:       st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_go && lo_lane && avs_address_in == EVT_STAT_OFS) begin
      st_nxt.evt = st_r.evt & ~avs_writedata_in[EVT_W-1:0];
    end
    if (wr_go && lo_lane && avs_address_in == EVT_MASK_OFS) begin
      st_nxt.mask = avs_writedata_in[EVT_W-1:0];
    end
    if (st_nxt.core.cmp_now) st_nxt.evt[EVT_CORE_CMP_BIT] = 1'b1;
    if (st_nxt.irqc.cmp_now) st_nxt.evt[EVT_IRQC_CMP_BIT] = 1'b1;
    if (st_nxt.core.st_err_now || st_nxt.irqc.st_err_now) st_nxt.evt[EVT_ST_FAIL_BIT] = 1'b1;
    if (bus_evt) st_nxt.evt[EVT_BUS_BIT] = 1'b1;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st_r         <= '0;
      st_r.core    <= '{mode: MODE_LOCK, cnt: CNT_ZERO, default: 1'b0};
      st_r.irqc    <= '{mode: MODE_LOCK, cnt: CNT_ZERO, default: 1'b0};
      st_r.mask    <= EVT_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    avs_waitrequest_out           = (avs_read_in || avs_write_in) && !st_r.ack;
    avs_readdata_out              = st_r.rdata;
    compare_error_out             = st_r.core.cmp_now || st_r.irqc.cmp_now; // RQ1
    selftest_error_out            = st_r.core.st_err_now || st_r.irqc.st_err_now; // RQ7
    comparator_status_channel_out = st_r.core.cmp_err || st_r.irqc.cmp_err
                                  || st_r.core.mode == MODE_SELF
                                  || st_r.irqc.mode == MODE_SELF; // RQ5
    bus_error_out                 = st_r.bus_err; // RQ13
    error_group_two_out           = !lockstep_in && error_group_two_in; // RQ16
    error_pin_n_out               = lockstep_in || error_pin_n_in; // RQ16
    irq_out                       = |(st_r.evt & st_r.mask);
  end

endmodule : lockstep_compare_monitor

// *** core/lockstep_pkg.sv ***
// Purpose : Constants and types for the lockstep compare monitor
// Assumes : One clock, Avalon-MM register access, byte addresses
// Notes   : Two compare blocks share one register layout
//
// How it works
// RQ1: Active mode compares cores and irq controllers.
// RQ2: Main core outputs delayed two cycles.
// RQ3: Four modes, chosen only by key writes.
// RQ4: Each block owns key and status registers.
// RQ5: Status channel shows mismatch or self test.
// RQ6: Self test runs patterns, mismatch held off.
// RQ7: Self test fault raises self-test error.
// RQ8: Core block self test lasts 4947 cycles.
// RQ9: Irq block self test lasts 151 cycles.
// RQ10: Error forcing injects mismatch for one cycle.
// RQ11: Forcing per block, via its own key.
// RQ12: Self-test forcing pulses fault, reverts next cycle.
// RQ13: Checker core bus inputs checked against clamp.
// RQ14: Checker core issues no bus transactions.
// RQ15: Powered-off masters watched for stray traffic.
// RQ16: In lockstep group-two irqs off, pin high.
// RQ17: Software initialises both cores' registers identically.
package lockstep_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CORE_KEY_OFS   = 8'h00;
  localparam logic [7:0] CORE_STAT_OFS  = 8'h04;
  localparam logic [7:0] IRQC_KEY_OFS   = 8'h08;
  localparam logic [7:0] IRQC_STAT_OFS  = 8'h0c;
  localparam logic [7:0] EVT_STAT_OFS   = 8'h10;
  localparam logic [7:0] EVT_MASK_OFS   = 8'h14;

  // ------------------------------------------------------------
  // Mode keys and field positions
  // ------------------------------------------------------------
  localparam logic [3:0] KEY_LOCKSTEP   = 4'h0;
  localparam logic [3:0] KEY_SELFTEST   = 4'h6;
  localparam logic [3:0] KEY_FORCE      = 4'h9;
  localparam logic [3:0] KEY_ST_FORCE   = 4'hf;

  localparam int STAT_CMP_BIT     = 0;
  localparam int STAT_DONE_BIT    = 1;
  localparam int STAT_FAIL_BIT    = 2;
  localparam int STAT_MODE_LSB    = 4;

  localparam int EVT_CORE_CMP_BIT = 0;
  localparam int EVT_IRQC_CMP_BIT = 1;
  localparam int EVT_ST_FAIL_BIT  = 2;
  localparam int EVT_BUS_BIT      = 3;
  localparam int EVT_W            = 4;

  localparam logic [EVT_W-1:0] EVT_MASK_RST = 4'h0;

  // ------------------------------------------------------------
  // Cycle counts
  // ------------------------------------------------------------
  localparam int          CORE_DELAY_CYC = 2;
  localparam int          CORE_ST_CYC    = 4947;
  localparam logic [15:0] IRQC_ST_CYC    = 16'h0097;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LOCK    = 2'b00,
    MODE_SELF    = 2'b01,
    MODE_FORCE   = 2'b10,
    MODE_STFORCE = 2'b11
  } mode_e;

  typedef struct packed {
    mode_e       mode;
    logic [15:0] cnt;
    logic        cmp_err;
    logic        st_done;
    logic        st_fail;
    logic        cmp_now;
    logic        st_err_now;
  } blk_s;

  typedef struct packed {
    logic       we;
    logic [3:0] key;
    logic       clr_we;
    logic [2:0] clr;
  } blk_wr_s;

endpackage : lockstep_pkg

// *** verif/core_pair_model.sv ***
// Purpose: Lockstep core pair and irq controller pair
// Assumes: Checker core runs two cycles behind
// Notes  : Flip inputs invert checker outputs for as long as they are held high
`timescale 1ns/10ps
module core_pair_model #(
  parameter int CORE_W = 32,
  parameter int IRQC_W = 16,
  parameter int BUS_W  = 16
) (
  input  wire logic         clock_in,
  input  wire logic         reset_in,
  input  wire logic         core_flip_in,
  input  wire logic         irqc_flip_in,
  input  wire logic         stray_in,
  output logic [CORE_W-1:0] core_main_out,
  output logic [CORE_W-1:0] core_check_out,
  output logic [IRQC_W-1:0] irqc_main_out,
  output logic [IRQC_W-1:0] irqc_check_out,
  output logic [BUS_W-1:0]  checker_bus_out
);
  logic [CORE_W-1:0] seq_r, d1_r, d2_r;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      seq_r <= '0;
      d1_r  <= '0;
      d2_r  <= '0;
    end else begin
      seq_r <= seq_r + CORE_W'(1);
      d1_r  <= seq_r;
      d2_r  <= d1_r;
    end
  end

  assign core_main_out   = seq_r;
  assign core_check_out  = d2_r ^ {CORE_W{core_flip_in}};
  assign irqc_main_out   = seq_r[IRQC_W-1:0];
  assign irqc_check_out  = seq_r[IRQC_W-1:0] ^ {IRQC_W{irqc_flip_in}};
  assign checker_bus_out = {BUS_W{stray_in}};
endmodule : core_pair_model

// *** verif/lockstep_compare_monitor_props.sv ***
// Purpose: Port assertions for the lockstep monitor
// Assumes: Parameters match the design
// Notes  : Bound from the testbench
`timescale 1ns/10ps
module lockstep_compare_monitor_props #(
  parameter int CORE_W = 32,
  parameter int IRQC_W = 16,
  parameter int BUS_W = 16,
  parameter int MASTERS = 4,
  parameter logic [BUS_W-1:0] BUS_CLAMP = '0
) (
  input wire logic clock_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out,
  input wire logic [CORE_W-1:0]  core_main_in, core_check_in,
  input wire logic [IRQC_W-1:0]  irqc_main_in, irqc_check_in,
  input wire logic               lockstep_in, error_group_two_in, error_pin_n_in,
  input wire logic [BUS_W-1:0]   checker_bus_in,
  input wire logic [MASTERS-1:0] master_active_in, domain_off_in,
  input wire logic compare_error_out, selftest_error_out, comparator_status_channel_out,
  input wire logic bus_error_out, error_group_two_out, error_pin_n_out
);
  logic [1:0] age_r;
  wire        viol_w = lockstep_in && (checker_bus_in != BUS_CLAMP || (master_active_in & domain_off_in) != '0);

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in)
      age_r <= 2'd0;
    else if (age_r != 2'd3)
      age_r <= age_r + 2'd1;
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  a_core_delay: assert property (
    age_r == 2'd3 && !comparator_status_channel_out && core_check_in != $past(core_main_in, 2) |=> compare_error_out)
    else $error("core mismatch missed");
  a_irqc_cmp: assert property (
    age_r != 2'd0 && !comparator_status_channel_out && irqc_check_in != irqc_main_in |=> compare_error_out)
    else $error("irq mismatch missed");
  a_err_status: assert property (
    compare_error_out |-> ##[0:1] comparator_status_channel_out) else $error("status channel low");
  a_fault_pulse: assert property (
    $rose(selftest_error_out) |=> !selftest_error_out) else $error("fault pulse too long");
  a_bus_flag: assert property (viol_w |=> bus_error_out) else $error("bus error missed");
  a_bus_quiet: assert property (!viol_w |=> !bus_error_out) else $error("spurious bus error");
  a_lock_quiet: assert property (
    lockstep_in |-> !error_group_two_out && error_pin_n_out) else $error("group two active in lockstep");
  a_pass_thru: assert property (
    !lockstep_in |-> error_pin_n_out == error_pin_n_in && error_group_two_out == error_group_two_in)
    else $error("pass through broken");
  a_one_wait: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no bus answer");
endmodule : lockstep_compare_monitor_props

// *** verif/lockstep_compare_monitor_tb.sv ***
// Purpose: Self-checking bench for the lockstep monitor
// Assumes: Core self test shortened to 20 cycles
// Notes  : Checker bound below the module
`timescale 1ns/10ps
module lockstep_compare_monitor_tb;
  import lockstep_pkg::*;
  localparam int ST_LEN = 20;
  logic clock_in = 1'b0, reset_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [7:0]  avs_address_in = 8'h00;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
  logic [3:0]  avs_byteenable_in = 4'hf, master_active_in = 4'h0, domain_off_in = 4'h0;
  logic [31:0] core_main_in, core_check_in;
  logic [15:0] irqc_main_in, irqc_check_in, checker_bus_in;
  logic lockstep_in = 1'b1, error_group_two_in = 1'b0, error_pin_n_in = 1'b1;
  logic core_flip = 1'b0, irqc_flip = 1'b0, stray = 1'b0;
  logic avs_waitrequest_out, compare_error_out, selftest_error_out, comparator_status_channel_out;
  logic bus_error_out, error_group_two_out, error_pin_n_out, irq_out;
  int   n_fail = 0, total_checks = 0, ce_n, se_n, sc_n, be_n;

  lockstep_compare_monitor #(.CORE_ST_LEN(ST_LEN)) i_lockstep_compare_monitor (.*);
  core_pair_model i_core_pair_model (.clock_in, .reset_in, .core_flip_in(core_flip), .irqc_flip_in(irqc_flip),
    .stray_in(stray), .core_main_out(core_main_in), .core_check_out(core_check_in),
    .irqc_main_out(irqc_main_in), .irqc_check_out(irqc_check_in), .checker_bus_out(checker_bus_in));

  always #2.5 clock_in = ~clock_in;

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= w;
    avs_read_in      <= !w;
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      conclude();
    end
  endtask : acc

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc

  task automatic watch(input int c);
    repeat (c) begin
      @(posedge clock_in);
      ce_n += int'(compare_error_out === 1'b1);
      se_n += int'(selftest_error_out === 1'b1);
      sc_n += int'(comparator_status_channel_out === 1'b1);
      be_n += int'(bus_error_out === 1'b1);
    end
  endtask : watch

  task automatic flip(input int b, input logic v);
    if (b == 0)
      core_flip <= v;
    else
      irqc_flip <= v;
  endtask : flip

  initial begin
    int b, len, f;
    logic [7:0] so, ko;
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 7; i++) rdc(8'(4 * i), 32'h0);
    ce_n = 0;
    watch(30);
    chk(32'(ce_n), 32'h0);
    for (b = 0; b < 6; b++) begin
      so = b[0] ? IRQC_STAT_OFS : CORE_STAT_OFS;
      ko = b[0] ? IRQC_KEY_OFS : CORE_KEY_OFS;
      f = int'(b < 4 && b > 1);
      ce_n = 0;
      se_n = 0;
      if (b < 2) begin
        flip(b, 1'b1);
        watch(1);
        flip(b, 1'b0);
      end else begin
        acc(1'b1, ko, f ? 32'(KEY_FORCE) : 32'(KEY_ST_FORCE));
      end
      watch(6);
      chk(32'(ce_n), 32'(b < 4));
      chk(32'(se_n), 32'(b > 3));
      chk(32'(comparator_status_channel_out), 32'(b < 4));
      rdc(so, b < 4 ? 32'h1 : 32'h4);
      rdc(so ^ 8'h08, 32'h0);
      rdc(ko, 32'h0);
      rdc(EVT_STAT_OFS, b < 4 ? 32'(1 << b[0]) : 32'h4);
      chk(32'(irq_out), 32'h0);
      acc(1'b1, EVT_MASK_OFS, 32'hf);
      watch(1);
      chk(32'(irq_out), 32'h1);
      acc(1'b1, EVT_STAT_OFS, 32'hf);
      watch(1);
      chk(32'(irq_out), 32'h0);
      acc(1'b1, so, 32'h7);
      acc(1'b1, EVT_MASK_OFS, 32'h0);
    end
    for (b = 0; b < 2; b++) begin
      so = b[0] ? IRQC_STAT_OFS : CORE_STAT_OFS;
      ko = b[0] ? IRQC_KEY_OFS : CORE_KEY_OFS;
      len = b ? int'(IRQC_ST_CYC) : ST_LEN;
      ce_n = 0;
      sc_n = 0;
      acc(1'b1, ko, 32'(KEY_SELFTEST));
      flip(b, 1'b1);
      watch(1);
      flip(b, 1'b0);
      watch(len + 9);
      chk(32'(ce_n), 32'h0);
      chk(32'(sc_n), 32'(len));
      rdc(so, 32'h2);
      rdc(ko, 32'h0);
      acc(1'b1, so, 32'h7);
    end
    acc(1'b1, CORE_KEY_OFS, 32'h3);
    avs_byteenable_in <= 4'he;
    acc(1'b1, CORE_KEY_OFS, 32'(KEY_SELFTEST));
    avs_byteenable_in <= 4'hf;
    rdc(CORE_KEY_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      be_n = 0;
      lockstep_in      <= (i != 3);
      stray            <= (i == 0 || i == 3);
      master_active_in <= (i == 1 || i == 2) ? 4'h2 : 4'h0;
      domain_off_in    <= (i == 2) ? 4'h4 : 4'h2;
      watch(1);
      stray            <= 1'b0;
      master_active_in <= 4'h0;
      watch(4);
      chk(32'(be_n), 32'(i < 2));
    end
    rdc(EVT_STAT_OFS, 32'h8);
    error_group_two_in <= 1'b1;
    error_pin_n_in     <= 1'b0;
    for (b = 0; b < 2; b++) begin
      lockstep_in <= b[0];
      watch(1);
      chk(32'(error_group_two_out), 32'(!b[0]));
      chk(32'(error_pin_n_out), 32'(b[0]));
    end
    conclude();
  end
endmodule : lockstep_compare_monitor_tb

bind lockstep_compare_monitor lockstep_compare_monitor_props #(.CORE_W(CORE_W), .IRQC_W(IRQC_W),
  .BUS_W(BUS_W), .MASTERS(MASTERS), .BUS_CLAMP(BUS_CLAMP)) i_lockstep_compare_monitor_props (.*);
